// ===== hw/tcc_consts.vh
// Constants for the timer channel control block: offsets, fields, codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TCC_ADR_CTRL0 8'h00
`define TCC_ADR_CTRL1 8'h04
`define TCC_ADR_EXTCFG 8'h08
`define TCC_ADR_CNT0 8'h0c
`define TCC_ADR_CNT1 8'h10

// ****************************************************************
// Reset values
// ****************************************************************
`define TCC_CTRL_RST 8'h00
`define TCC_EXTCFG_RST 5'h10
`define TCC_CNT_RST 16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define TCC_SRC_MSB 2
`define TCC_SRC_LSB 0
`define TCC_EDGE_MSB 4
`define TCC_EDGE_LSB 3
`define TCC_CLR_MSB 7
`define TCC_CLR_LSB 5
`define TCC_CFG_CHOICE0 0
`define TCC_CFG_CHOICE1 1
`define TCC_CFG_EXT_EN 2
`define TCC_CFG_SYNC 3
`define TCC_CFG_TMODE 4

// ****************************************************************
// Field codes
// ****************************************************************
`define TCC_SRC_F1 3'h0
`define TCC_SRC_F2 3'h1
`define TCC_SRC_F4 3'h2
`define TCC_SRC_F8 3'h3
`define TCC_SRC_F32 3'h4
`define TCC_SRC_EXT 3'h5
`define TCC_SRC_OSC40 3'h6
`define TCC_SRC_FAST 3'h7
`define TCC_EDGE_RISE 2'h0
`define TCC_EDGE_FALL 2'h1
`define TCC_EDGE_BOTH 2'h2
`define TCC_CLR_NONE 3'h0
`define TCC_CLR_A 3'h1
`define TCC_CLR_B 3'h2
`define TCC_CLR_SYNC 3'h3
`define TCC_CLR_C 3'h5
`define TCC_CLR_D 3'h6

// ****************************************************************
// Prescaler tick masks on the free divider
// ****************************************************************
`define TCC_DIV_W 5
`define TCC_DIV2_MASK 5'h01
`define TCC_DIV4_MASK 5'h03
`define TCC_DIV8_MASK 5'h07
`define TCC_DIV32_MASK 5'h1f

`endif

// ===== hw/tcc_src_sel.v
// Count source and external edge selector for one timer channel.
// Assumes all tick inputs are one-cycle pulses on core_clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.vh"

module tcc_src_sel (
  // Prescaled ticks: f1, f2, f4, f8, f32
  input wire [4:0] pre_tick_i,
  // Synchronised edge pulses
  input wire ext_rise_i,
  input wire ext_fall_i,
  input wire alt_rise_i,
  input wire osc40_rise_i,
  input wire fast_rise_i,
  // Control fields
  input wire [2:0] src_sel_i,
  input wire [1:0] edge_sel_i,
  input wire clock_input_choice_i,
  input wire ext_input_enable_i,
  input wire timer_mode_i,
  // Result
  output reg count_tick_o
);

  reg ext_tick;

  // Edge choice for the pin; code 11 never counts
  always @* begin
    case (edge_sel_i)
      `TCC_EDGE_RISE: ext_tick = ext_rise_i;
      `TCC_EDGE_FALL: ext_tick = ext_fall_i;
      `TCC_EDGE_BOTH: ext_tick = ext_rise_i | ext_fall_i;
      default: ext_tick = 1'b0;
    endcase
  end

  // Source mux; pin and alternate clock share one code
  always @* begin
    case (src_sel_i)
      `TCC_SRC_F1: count_tick_o = pre_tick_i[0];
      `TCC_SRC_F2: count_tick_o = pre_tick_i[1];
      `TCC_SRC_F4: count_tick_o = pre_tick_i[2];
      `TCC_SRC_F8: count_tick_o = pre_tick_i[3];
      `TCC_SRC_F32: count_tick_o = pre_tick_i[4];
      `TCC_SRC_EXT: begin
        if (!clock_input_choice_i)
          count_tick_o = ext_input_enable_i & ext_tick;
        else
          count_tick_o = timer_mode_i & alt_rise_i;
      end
      `TCC_SRC_OSC40: count_tick_o = osc40_rise_i;
      `TCC_SRC_FAST: count_tick_o = fast_rise_i;
      default: count_tick_o = 1'b0;
    endcase
  end

endmodule // tcc_src_sel
`default_nettype wire

// ===== hw/tcc_timer_ctrl.v
// Two-channel timer control: registers, count source, counter clear.
// Assumes a classic Wishbone master on core_clk_i and compare match
// pulses from outside compare logic on the same clock.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.vh"

module tcc_timer_ctrl (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Asynchronous clock sources
  input wire ext_count_clock_pin_i,
  input wire alt_internal_clock_i,
  input wire osc_40m_clock_i,
  input wire fast_osc_clock_i,
  // Compare match pulses, bit i is channel i
  input wire [1:0] match_a_i,
  input wire [1:0] match_b_i,
  input wire [1:0] match_c_i,
  input wire [1:0] match_d_i,
  // Counter state
  output reg [15:0] channel_counter0_o,
  output reg [15:0] channel_counter1_o,
  output reg [1:0] counter_clear_o
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Clear request from a channel's own compare matches
  function own_clear;
    input [2:0] code;
    input ma;
    input mb;
    input mc;
    input md;
    begin
      case (code)
        `TCC_CLR_NONE: own_clear = 1'b0;
        `TCC_CLR_A: own_clear = ma;
        `TCC_CLR_B: own_clear = mb;
        `TCC_CLR_C: own_clear = mc;
        `TCC_CLR_D: own_clear = md;
        // Reserved codes never clear, so a stray write is harmless
        default: own_clear = 1'b0;
      endcase
    end
  endfunction

  // Word-aligned address match
  function adr_hit;
    input [7:0] adr;
    input [7:0] offs;
    begin
      adr_hit = ({adr[7:2], 2'b00} == offs);
    end
  endfunction

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [7:0] ctrl_reg [0:1];
  reg [4:0] extcfg_reg;
  reg [15:0] cnt_reg [0:1];
  reg [`TCC_DIV_W-1:0] div_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] sync3_reg;

  wire bus_req;
  wire bus_wr;
  wire wr_lane0;
  reg [31:0] rd_data;

  // A new request is one not yet answered; ack drops next cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  // Control registers are 8 bits wide and live in lane 0
  assign wr_lane0 = bus_wr & wb_sel_i[0];

  // ****************************************************************
  // Wishbone answer
  // ****************************************************************

  // Read mux; unmapped offsets answer zero rather than hang the bus
  always @* begin
    rd_data = 32'h00000000;
    if (adr_hit(wb_adr_i, `TCC_ADR_CTRL0))
      rd_data = {24'h000000, ctrl_reg[0]};
    else if (adr_hit(wb_adr_i, `TCC_ADR_CTRL1))
      rd_data = {24'h000000, ctrl_reg[1]};
    else if (adr_hit(wb_adr_i, `TCC_ADR_EXTCFG))
      rd_data = {27'h0000000, extcfg_reg};
    else if (adr_hit(wb_adr_i, `TCC_ADR_CNT0))
      rd_data = {16'h0000, cnt_reg[0]};
    else if (adr_hit(wb_adr_i, `TCC_ADR_CNT1))
      rd_data = {16'h0000, cnt_reg[1]};
  end

  // One-cycle ack; data is latched with it so it stands stable
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req)
        wb_dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Software writes
  // ****************************************************************

  // Control and configuration registers; counters are read-only
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_reg[0] <= `TCC_CTRL_RST;
      ctrl_reg[1] <= `TCC_CTRL_RST;
      extcfg_reg <= `TCC_EXTCFG_RST;
    end else if (wr_lane0) begin
      if (adr_hit(wb_adr_i, `TCC_ADR_CTRL0))
        ctrl_reg[0] <= wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TCC_ADR_CTRL1))
        ctrl_reg[1] <= wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TCC_ADR_EXTCFG))
        extcfg_reg <= wb_dat_i[4:0];
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************

  // Free divider; a tick fires when the low bits are all ones.
  // Sharing one divider keeps all prescaled ticks phase aligned.
  always @(posedge core_clk_i) begin
    if (rst_i)
      div_reg <= {`TCC_DIV_W{1'b0}};
    else
      div_reg <= div_reg + 1'b1;
  end

  wire [4:0] pre_tick;

  assign pre_tick[0] = 1'b1;
  assign pre_tick[1] = &(div_reg | ~`TCC_DIV2_MASK);
  assign pre_tick[2] = &(div_reg | ~`TCC_DIV4_MASK);
  assign pre_tick[3] = &(div_reg | ~`TCC_DIV8_MASK);
  assign pre_tick[4] = &(div_reg | ~`TCC_DIV32_MASK);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // Two flops before any use, a third only for edge detection.
  // Sources near or above half of core_clk_i alias; that is a
  // limitation of sampling rather than a separate clock domain.
  wire [3:0] async_in;

  assign async_in = {fast_osc_clock_i, osc_40m_clock_i,
                     alt_internal_clock_i, ext_count_clock_pin_i};

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  wire [3:0] rise;
  wire [3:0] fall;

  assign rise = sync2_reg & ~sync3_reg;
  assign fall = ~sync2_reg & sync3_reg;

  // ****************************************************************
  // Per-channel source selection and clear decode
  // ****************************************************************
  wire [1:0] count_tick;
  wire [1:0] clr_own;
  wire [1:0] clr_all;
  wire sync_en;

  assign sync_en = extcfg_reg[`TCC_CFG_SYNC];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      wire [2:0] clr_code;

      assign clr_code = ctrl_reg[g][`TCC_CLR_MSB:`TCC_CLR_LSB];

      tcc_src_sel u_src (
        .pre_tick_i(pre_tick),
        .ext_rise_i(rise[0]),
        .ext_fall_i(fall[0]),
        .alt_rise_i(rise[1]),
        .osc40_rise_i(rise[2]),
        .fast_rise_i(rise[3]),
        .src_sel_i(ctrl_reg[g][`TCC_SRC_MSB:`TCC_SRC_LSB]),
        .edge_sel_i(ctrl_reg[g][`TCC_EDGE_MSB:`TCC_EDGE_LSB]),
        .clock_input_choice_i(extcfg_reg[`TCC_CFG_CHOICE0 + g]),
        .ext_input_enable_i(extcfg_reg[`TCC_CFG_EXT_EN]),
        .timer_mode_i(extcfg_reg[`TCC_CFG_TMODE]),
        .count_tick_o(count_tick[g])
      );

      // Own compare clear for this channel
      assign clr_own[g] = own_clear(clr_code, match_a_i[g],
                                    match_b_i[g], match_c_i[g],
                                    match_d_i[g]);

      // Follow the other channel's clear only in sync operation.
      // Both channels on the sync code have no cause and never clear.
      assign clr_all[g] = clr_own[g] |
                          (sync_en & (clr_code == `TCC_CLR_SYNC) &
                           clr_own[1-g]);
    end
  endgenerate

  // ****************************************************************
  // Counters
  // ****************************************************************

  // Clear beats a tick in the same cycle; counting resumes from zero
  // on the next tick of the selected source.
  integer i;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 2; i = i + 1)
        cnt_reg[i] <= `TCC_CNT_RST;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (clr_all[i])
          cnt_reg[i] <= `TCC_CNT_RST;
        else if (count_tick[i])
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Mirrors lag the counters by one cycle so outputs come from flops
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      channel_counter0_o <= `TCC_CNT_RST;
      channel_counter1_o <= `TCC_CNT_RST;
      counter_clear_o <= 2'h0;
    end else begin
      channel_counter0_o <= cnt_reg[0];
      channel_counter1_o <= cnt_reg[1];
      counter_clear_o <= clr_all;
    end
  end

endmodule // tcc_timer_ctrl
`default_nettype wire

// ===== test/tcc_timer_ctrl_assertions.sv
// Checker for the timer channel control block, watching its ports only.
// Assumes it is bound onto tcc_timer_ctrl by the statement at the foot.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_ctrl_chk (
  // Clock, reset and bus
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Matches and counter state
  input wire logic [1:0] match_a_i,
  input wire logic [1:0] match_c_i,
  input wire logic [15:0] channel_counter0_o,
  input wire logic [15:0] channel_counter1_o,
  input wire logic [1:0] counter_clear_o
);
  logic [2:0] clr0_reg;
  wire req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // Shadow of the channel 0 clear field, updated on the taking edge
  // ****************************************************************
  always @(posedge core_clk_i) begin
    if (rst_i)
      clr0_reg <= 3'h0;
    else if (req && wb_we_i && !wb_ack_o && wb_sel_i[0]
             && wb_adr_i[7:2] == 6'h00)
      clr0_reg <= wb_dat_i[7:5];
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_no_stray_ack: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  chk_clear_zero_ch0: assert property (counter_clear_o[0] |=>
    channel_counter0_o == 16'h0000) else $error("ch0 not zero on clear");
  chk_clear_zero_ch1: assert property (counter_clear_o[1] |=>
    channel_counter1_o == 16'h0000) else $error("ch1 not zero on clear");
  chk_step_ch0: assert property ($changed(channel_counter0_o) |->
    channel_counter0_o == $past(channel_counter0_o) + 16'h0001
    || channel_counter0_o == 16'h0000) else $error("ch0 bad step");
  chk_step_ch1: assert property ($changed(channel_counter1_o) |->
    channel_counter1_o == $past(channel_counter1_o) + 16'h0001
    || channel_counter1_o == 16'h0000) else $error("ch1 bad step");
  chk_clear_on_a: assert property (match_a_i[0] && clr0_reg == 3'h1
    |-> ##1 counter_clear_o[0]) else $error("no clear on match a");
  chk_clear_on_c: assert property (match_c_i[0] && clr0_reg == 3'h5
    |-> ##1 counter_clear_o[0]) else $error("no clear on match c");
  chk_no_clear_idle: assert property ($past(clr0_reg) inside
    {3'h0, 3'h4, 3'h7} |-> !counter_clear_o[0])
    else $error("clear with clearing off");
  // Main scenarios reached
  cover property (counter_clear_o == 2'b11);
  cover property (counter_clear_o == 2'b01);
  cover property (req && wb_we_i && wb_ack_o);
endmodule // tcc_timer_ctrl_chk

bind tcc_timer_ctrl tcc_timer_ctrl_chk u_chk (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .match_a_i(match_a_i),
  .match_c_i(match_c_i), .channel_counter0_o(channel_counter0_o),
  .channel_counter1_o(channel_counter1_o),
  .counter_clear_o(counter_clear_o));
`default_nettype wire

// ===== test/tcc_timer_ctrl_tb_top.sv
// Self-checking bench for the timer channel control block.
// Assumes the design's constants header is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_timer_ctrl_tb_top;
  logic clk, rst, cyc, stb, we;
  logic [7:0] adr, mt;
  logic [3:0] sel, src;
  logic [31:0] dat, q;
  logic [15:0] c0;
  wire [31:0] rd;
  wire ack;
  wire [15:0] cnt0, cnt1;
  wire [1:0] clr;
  integer fail_count, total_checks, i, j;
  logic [20:0] codes;
  logic [11:0] cmap;

  tcc_timer_ctrl dut (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .ext_count_clock_pin_i(src[0]), .alt_internal_clock_i(src[1]),
    .osc_40m_clock_i(src[2]), .fast_osc_clock_i(src[3]),
    .match_a_i(mt[1:0]), .match_b_i(mt[3:2]), .match_c_i(mt[5:4]),
    .match_d_i(mt[7:6]), .channel_counter0_o(cnt0),
    .channel_counter1_o(cnt1), .counter_clear_o(clr));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        $display("unexpected %s: expected %h seen %h", nm, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask

  // One classic cycle; the idle edge at the end keeps cycles apart
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      n = 0;
      do begin @(posedge clk); n = n + 1; end
      while (ack !== 1'b1 && n < 50);
      q = rd;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 50) begin fail_count = fail_count + 1; finish_test; end
      @(posedge clk);
    end
  endtask

  task rdchk(input [7:0] a, input [31:0] e, input string nm);
    begin bus(1'b0, a, 32'h0, 4'h0); chk(nm, e, q); end
  endtask

  // Count ticks over 64 cycles (k < 0) or over 3 pulses on input k
  task meas(input [7:0] ctl, input integer k, input integer e);
    begin
      bus(1'b1, `TCC_ADR_CTRL0, {24'h0, ctl}, 4'h1);
      c0 = cnt0;
      if (k < 0) repeat (64) @(posedge clk);
      else begin
        repeat (3) begin
          src[k] <= 1'b1; repeat (4) @(posedge clk);
          src[k] <= 1'b0; repeat (4) @(posedge clk);
        end
        repeat (2) @(posedge clk); // Synchroniser lag
      end
      chk("count step", e, {16'h0, cnt0 - c0});
    end
  endtask

  // Pulse match k on channel 0, expect clear pulses e one edge later
  task clrt(input [2:0] code, input integer k, input [1:0] e);
    begin
      bus(1'b1, `TCC_ADR_CTRL0, {24'h0, code, 5'h00}, 4'h1);
      mt[2*k] <= 1'b1; @(posedge clk);
      // Clear pulse stands in the cycle after the match edge
      mt[2*k] <= 1'b0; @(posedge clk);
      chk("clear pulse", {30'h0, e}, {30'h0, clr});
      // Mirrors show the zero one cycle after the pulse
      @(posedge clk);
      if (e[0]) chk("counter after clear", 32'h0, {16'h0, cnt0});
      if (e[1]) chk("counter1 after clear", 32'h0, {16'h0, cnt1});
      @(posedge clk);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    sel = 4'h0; dat = 32'h0; src = 4'h0; mt = 8'h00;
    fail_count = 0; total_checks = 0;
    codes = {3'h7, 3'h4, `TCC_CLR_D, `TCC_CLR_C, `TCC_CLR_B, `TCC_CLR_A,
             `TCC_CLR_NONE};
    cmap = {`TCC_CLR_D, `TCC_CLR_C, `TCC_CLR_B, `TCC_CLR_A};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, ignored byte lane, unmapped place, read back
    rdchk(`TCC_ADR_CTRL0, {24'h0, `TCC_CTRL_RST}, "ctrl0 reset");
    rdchk(`TCC_ADR_EXTCFG, {27'h0, `TCC_EXTCFG_RST}, "extcfg reset");
    bus(1'b1, `TCC_ADR_CTRL1, 32'hff, 4'h0);
    rdchk(`TCC_ADR_CTRL1, 32'h0, "ctrl1 lane off");
    bus(1'b1, 8'h40, 32'h5a, 4'hf);
    rdchk(8'h40, 32'h0, "unmapped");
    bus(1'b1, `TCC_ADR_CTRL0, 32'hff, 4'h1);
    rdchk(`TCC_ADR_CTRL0, 32'hff, "ctrl0 rw");
    $display("test registers done");
    // Prescaled sources over a window that all dividers fit
    for (i = 0; i < 5; i = i + 1)
      meas({5'h00, i[2:0]}, -1, 64 >> ((i == 4) ? 5 : i));
    // External pin edges, enable and alternate clock choice
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h14, 4'h1);
    for (i = 0; i < 4; i = i + 1)
      meas({3'h0, i[1:0], `TCC_SRC_EXT}, 0,
           (i == 2) ? 6 : (i == 3) ? 0 : 3);
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h10, 4'h1);
    meas({5'h00, `TCC_SRC_EXT}, 0, 0);
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h15, 4'h1);
    meas({5'h00, `TCC_SRC_EXT}, 0, 0);
    meas({5'h00, `TCC_SRC_EXT}, 1, 3);
    // Alternate clock is ignored outside timer mode
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h01, 4'h1);
    meas({5'h00, `TCC_SRC_EXT}, 1, 0);
    meas({5'h00, `TCC_SRC_OSC40}, 2, 3);
    meas({5'h00, `TCC_SRC_FAST}, 3, 3);
    $display("test sources done");
    // Every clear code except the sync code against every compare match
    for (i = 0; i < 7; i = i + 1)
      for (j = 0; j < 4; j = j + 1)
        clrt(codes[3*i +: 3], j,
             {1'b0, codes[3*i +: 3] == cmap[3*j +: 3]});
    // Synchronous clear with and without sync operation
    bus(1'b1, `TCC_ADR_CTRL1, 32'h60, 4'h1);
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h18, 4'h1);
    clrt(`TCC_CLR_A, 0, 2'b11);
    bus(1'b1, `TCC_ADR_EXTCFG, 32'h10, 4'h1);
    clrt(`TCC_CLR_A, 0, 2'b01);
    $display("test clears done");
    finish_test;
  end
endmodule // tcc_timer_ctrl_tb_top
`default_nettype wire
